// *** logic/fdrc_top.v ***
/*
  Fan drive ramp and floor control: AXI4-Lite register file, floor
  selection in automatic mode, ramp limiting of output 1, three duty
  generators and tach edge counting grouped to output 3.
  Assumes computed duties and threshold flags come from same-clock logic;
  tach pins are asynchronous.
*/
// Added by the designer: the AXI4-Lite slave port and the address map.
// Operation
// RULE1 - three-bit code selects step 1..48
// RULE2 - output 1 ramps gradually, sweep time bounded
// RULE3 - smoothing bit set enables output 1 ramp
// RULE4 - group bit one ties tach 2,3,4 to output 3
// RULE5 - group bit zero ties only tach 3,4
// RULE6 - output 1 below threshold: zero or minimum
// RULE7 - output 2 below threshold: zero or minimum
// RULE8 - output 3 below threshold: zero or minimum
// RULE9 - smoothing off applies new duty at once
`timescale 1ns/1ns
`include "fdrc_defines.vh"

module fdrc_top
#(
  parameter SLOT_CYCLES = (`FDRC_SWEEP_SLOW_US * `FDRC_CLK_MHZ) / `FDRC_SWEEP_STEPS
)
(
  input wire clk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire auto_mode,
  input wire below_hyst_1,
  input wire below_hyst_2,
  input wire below_hyst_3,
  input wire [7:0] computed_duty_1,
  input wire [7:0] computed_duty_2,
  input wire [7:0] computed_duty_3,
  input wire fan_speed_in_2,
  input wire fan_speed_in_3,
  input wire fan_speed_in_4,
  output reg fan_drive_out_1,
  output reg fan_drive_out_2,
  output reg fan_drive_out_3
);

  // floor selection in automatic mode below threshold minus hysteresis
  function [7:0] floor_duty;
    input auto_on;
    input below;
    input floor_sel;
    input [7:0] min_duty;
    input [7:0] computed;
    begin
      if (auto_on && below)
        floor_duty = floor_sel ? min_duty : `FDRC_DUTY_OFF;
      else
        floor_duty = computed;
    end
  endfunction

  // address decode: true for a mapped offset
  function mapped;
    input [7:0] addr;
    begin
      case (addr)
        `FDRC_OFF_CTRL, `FDRC_OFF_FLOOR_SELECT_1, `FDRC_OFF_FLOOR_SELECT_2, `FDRC_OFF_FLOOR_SELECT_3,
        `FDRC_OFF_OUT1, `FDRC_OFF_OUT2, `FDRC_OFF_OUT3, `FDRC_OFF_TACH:
          mapped = 1'b1;
        default:
          mapped = 1'b0;
      endcase
    end
  endfunction

  reg [7:0] ctrl;
  reg [7:0] min_duty_1;
  reg [7:0] min_duty_2;
  reg [7:0] min_duty_3;
  reg [7:0] aw_addr;
  reg aw_held;
  reg [7:0] w_data;
  reg w_lane0;
  reg w_held;
  reg [31:0] slot_cnt;
  reg slot_tick;
  reg [7:0] pwm_cnt;
  reg [7:0] duty_2;
  reg [7:0] duty_3;
  wire [7:0] target_1;
  wire [7:0] target_2;
  wire [7:0] target_3;
  wire [7:0] duty_1;
  wire [2:0] tach_pins;
  wire [2:0] tach_gate;
  wire [23:0] tach_word;
  wire do_write;
  wire [7:0] duty_vec [0:2];

  // ---------------- register bus ----------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_addr <= 8'h00;
      aw_held <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      w_held <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FDRC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        w_held <= 1'b1;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? `FDRC_RESP_OKAY : `FDRC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // writable registers
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= `FDRC_CTRL_RST;
      min_duty_1 <= `FDRC_MIN_RST;
      min_duty_2 <= `FDRC_MIN_RST;
      min_duty_3 <= `FDRC_MIN_RST;
    end
    else if (do_write && w_lane0)
    begin
      case (aw_addr)
        `FDRC_OFF_CTRL: ctrl <= w_data;
        `FDRC_OFF_FLOOR_SELECT_1: min_duty_1 <= w_data;
        `FDRC_OFF_FLOOR_SELECT_2: min_duty_2 <= w_data;
        `FDRC_OFF_FLOOR_SELECT_3: min_duty_3 <= w_data;
        default: ctrl <= ctrl;
      endcase
    end
  end

  // read channel
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FDRC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `FDRC_RESP_OKAY : `FDRC_RESP_SLVERR;
      case (s_axi_araddr)
        `FDRC_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl};
        `FDRC_OFF_FLOOR_SELECT_1: s_axi_rdata <= {24'h000000, min_duty_1};
        `FDRC_OFF_FLOOR_SELECT_2: s_axi_rdata <= {24'h000000, min_duty_2};
        `FDRC_OFF_FLOOR_SELECT_3: s_axi_rdata <= {24'h000000, min_duty_3};
        `FDRC_OFF_OUT1: s_axi_rdata <= {24'h000000, duty_1};
        `FDRC_OFF_OUT2: s_axi_rdata <= {24'h000000, duty_2};
        `FDRC_OFF_OUT3: s_axi_rdata <= {24'h000000, duty_3};
        `FDRC_OFF_TACH: s_axi_rdata <= {8'h00, tach_word};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ---------------- floor selection ----------------
  // RULE6 output 1 floor
  assign target_1 = floor_duty(auto_mode, below_hyst_1, ctrl[`FDRC_FLOOR1_BIT], min_duty_1, computed_duty_1);
  // RULE7 output 2 floor
  assign target_2 = floor_duty(auto_mode, below_hyst_2, ctrl[`FDRC_FLOOR2_BIT], min_duty_2, computed_duty_2);
  // RULE8 output 3 floor
  assign target_3 = floor_duty(auto_mode, below_hyst_3, ctrl[`FDRC_FLOOR3_BIT], min_duty_3, computed_duty_3);

  // outputs 2 and 3 take their targets directly
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      duty_2 <= `FDRC_DUTY_RST;
      duty_3 <= `FDRC_DUTY_RST;
    end
    else
    begin
      duty_2 <= target_2;
      duty_3 <= target_3;
    end
  end

  // ---------------- ramp time slot ----------------
  // RULE2 slot period
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slot_cnt <= 32'h00000000;
      slot_tick <= 1'b0;
    end
    else if (slot_cnt >= SLOT_CYCLES - 1)
    begin
      slot_cnt <= 32'h00000000;
      slot_tick <= 1'b1;
    end
    else
    begin
      slot_cnt <= slot_cnt + 32'h00000001;
      slot_tick <= 1'b0;
    end
  end

  // RULE1 rate limited output 1
  fdrc_ramp fdrc_ramp_inst
  (
    .clk(clk),
    .rst_n(rst_n),
    .target(target_1),
    .smooth_en(ctrl[`FDRC_SMOOTH_BIT]),
    .rate_code(ctrl[`FDRC_RATE_MSB:`FDRC_RATE_LSB]),
    .slot_tick(slot_tick),
    .duty(duty_1)
  );

  // ---------------- duty generators ----------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pwm_cnt <= 8'h00;
    else if (pwm_cnt == `FDRC_DUTY_FULL - 8'h01)
      pwm_cnt <= 8'h00;
    else
      pwm_cnt <= pwm_cnt + 8'h01;
  end

  assign duty_vec[0] = duty_1;
  assign duty_vec[1] = duty_2;
  assign duty_vec[2] = duty_3;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fan_drive_out_1 <= 1'b0;
      fan_drive_out_2 <= 1'b0;
      fan_drive_out_3 <= 1'b0;
    end
    else
    begin
      fan_drive_out_1 <= pwm_cnt < duty_vec[0];
      fan_drive_out_2 <= pwm_cnt < duty_vec[1];
      fan_drive_out_3 <= pwm_cnt < duty_vec[2];
    end
  end

  // ---------------- tach inputs ----------------
  assign tach_pins = {fan_speed_in_4, fan_speed_in_3, fan_speed_in_2};

  // RULE4 group bit one gates tach 2
  // RULE5 group bit zero frees tach 2
  assign tach_gate[0] = ctrl[`FDRC_GROUP_BIT] ? fan_drive_out_3 : 1'b1;
  assign tach_gate[1] = fan_drive_out_3;
  assign tach_gate[2] = fan_drive_out_3;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_tach
      reg meta;
      reg sync;
      reg prev;
      reg [7:0] count;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta <= `FDRC_TACH_IDLE;
          sync <= `FDRC_TACH_IDLE;
          prev <= `FDRC_TACH_IDLE;
          count <= 8'h00;
        end
        else
        begin
          meta <= tach_pins[gi];
          sync <= meta;
          prev <= sync;
          // count rising edges only inside the drive window, and on tach 2 at any time when the group bit is zero
          if (sync && !prev && tach_gate[gi])
            count <= count + 8'h01;
        end
      end
      assign tach_word[8 * gi +: 8] = count;
    end
  endgenerate

endmodule

// *** logic/fdrc_defines.vh ***
/*
  Shared constants of the fan drive ramp and floor control block:
  register offsets, field positions, reset values, timing figures.
  Assumes it is included by bare name from the design files.
*/
`ifndef FDRC_DEFINES_VH
`define FDRC_DEFINES_VH

// register byte offsets
`define FDRC_OFF_CTRL 8'h00
`define FDRC_OFF_FLOOR_SELECT_1 8'h04
`define FDRC_OFF_FLOOR_SELECT_2 8'h08
`define FDRC_OFF_FLOOR_SELECT_3 8'h0C
`define FDRC_OFF_OUT1 8'h10
`define FDRC_OFF_OUT2 8'h14
`define FDRC_OFF_OUT3 8'h18
`define FDRC_OFF_TACH 8'h1C

// control register fields
`define FDRC_RATE_MSB 2
`define FDRC_RATE_LSB 0
`define FDRC_SMOOTH_BIT 3
`define FDRC_GROUP_BIT 4
`define FDRC_FLOOR1_BIT 5
`define FDRC_FLOOR2_BIT 6
`define FDRC_FLOOR3_BIT 7

// reset values, off and full duty levels
`define FDRC_CTRL_RST 8'h00
`define FDRC_MIN_RST 8'h00
`define FDRC_DUTY_RST 8'h00
`define FDRC_DUTY_OFF 8'h00
`define FDRC_DUTY_FULL 8'hFF

// ramp step per time slot for each rate code
`define FDRC_STEP_0 8'h01
`define FDRC_STEP_1 8'h02
`define FDRC_STEP_2 8'h03
`define FDRC_STEP_3 8'h04
`define FDRC_STEP_4 8'h08
`define FDRC_STEP_5 8'h0C
`define FDRC_STEP_6 8'h18
`define FDRC_STEP_7 8'h30

// timing: slowest full sweep in microseconds, clock in MHz, duty steps in a sweep
`define FDRC_SWEEP_SLOW_US 37500000
`define FDRC_CLK_MHZ 25
`define FDRC_SWEEP_STEPS 255

// bus answers
`define FDRC_RESP_OKAY 2'h0
`define FDRC_RESP_SLVERR 2'h2

// idle level of a tach pin, so no false edge follows reset
`define FDRC_TACH_IDLE 1'h1

`endif

// *** logic/fdrc_ramp.v ***
/*
  Rate limiter for fan drive output 1: steps the applied duty toward the
  requested duty by the selected amount once per time slot.
  Assumes slot_tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ns
`include "fdrc_defines.vh"

module fdrc_ramp
(
  input wire clk,
  input wire rst_n,
  input wire [7:0] target,
  input wire smooth_en,
  input wire [2:0] rate_code,
  input wire slot_tick,
  output reg [7:0] duty
);

  // step size per rate code
  function [7:0] step_of;
    input [2:0] code;
    begin
      case (code)
        3'h0: step_of = `FDRC_STEP_0;
        3'h1: step_of = `FDRC_STEP_1;
        3'h2: step_of = `FDRC_STEP_2;
        3'h3: step_of = `FDRC_STEP_3;
        3'h4: step_of = `FDRC_STEP_4;
        3'h5: step_of = `FDRC_STEP_5;
        3'h6: step_of = `FDRC_STEP_6;
        default: step_of = `FDRC_STEP_7;
      endcase
    end
  endfunction

  wire [7:0] step;
  reg [7:0] next_duty;

  assign step = step_of(rate_code);

  always @*
  begin
    next_duty = duty;
    // RULE9 direct apply
    if (!smooth_en)
      next_duty = target;
    // RULE3 smoothing enabled
    else if (slot_tick)
    begin
      // RULE1 step per slot
      // RULE2 gradual approach
      if (target > duty)
        next_duty = ((target - duty) > step) ? duty + step : target;
      else if (target < duty)
        next_duty = ((duty - target) > step) ? duty - step : target;
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      duty <= `FDRC_DUTY_RST;
    else
      duty <= next_duty;
  end

endmodule

// *** testbench/fdrc_fan_model.sv ***
/*
  fan model: a spinning fan whose tach line pulses freely.
  assumes the bench picks a half period per fan.
*/
`timescale 1ns/1ns
module fdrc_fan_model
#(
  parameter HALF_NS = 197
)
(
  output logic tach
);
  initial tach = 1'b1;
  // free-running pulse train, off the bench clock phase
  always #(HALF_NS) tach = !tach;
endmodule

// *** testbench/fdrc_asserts.sv ***
/*
  checker: bus answer and drive output assertions.
  assumes a bind from the bench top onto fdrc_top.
*/
`timescale 1ns/1ns
module fdrc_asserts
(
  input wire clk,
  input wire rst_n,
  input wire s_axi_awready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire auto_mode,
  input wire [7:0] computed_duty_2,
  input wire [7:0] computed_duty_3,
  input wire fan_drive_out_2,
  input wire fan_drive_out_3
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during answer");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rdata_hi_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr != 8'h1C
    |=> s_axi_rdata[31:8] == 24'h000000)
    else $error("read upper bits set");
  out2_full_a: assert property ((!auto_mode && computed_duty_2 == 8'hFF) [*3] |-> fan_drive_out_2)
    else $error("output 2 not full on");
  out3_off_a: assert property ((!auto_mode && computed_duty_3 == 8'h00) [*3] |-> !fan_drive_out_3)
    else $error("output 3 not off");
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (auto_mode && fan_drive_out_2);
endmodule

// *** testbench/fdrc_top_test.sv ***
/*
  bench for the fan drive ramp and floor block.
  assumes the design files, the fan model and the checker.
*/
`timescale 1ns/1ns
module fdrc_top_test;
  typedef struct packed {logic [7:0] c; logic a; logic [2:0] b; logic [23:0] e;} fdrc_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic auto_mode = 1'b0, below_hyst_1 = 1'b0, below_hyst_2 = 1'b0, below_hyst_3 = 1'b0;
  logic [7:0] computed_duty_1 = 8'h40, computed_duty_2 = 8'hFF, computed_duty_3 = 8'h60;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire fan_speed_in_2, fan_speed_in_3, fan_speed_in_4, fan_drive_out_1, fan_drive_out_2, fan_drive_out_3;
  wire [2:0] drive_pins = {fan_drive_out_3, fan_drive_out_2, fan_drive_out_1};
  logic [31:0] rdv, t0;
  logic [1:0] rsp;
  int n_tests = 0, n_mismatch = 0;
  logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h30};
  fdrc_row_t rows [5] = '{'{8'h00, 1'b0, 3'h7, 24'h60FF40}, '{8'hE0, 1'b1, 3'h7, 24'h332211},
    '{8'h00, 1'b1, 3'h7, 24'h000000}, '{8'hA0, 1'b1, 3'h5, 24'h33FF11}, '{8'h40, 1'b1, 3'h2, 24'h602240}};

  fdrc_top #(.SLOT_CYCLES(16)) fdrc_top_inst (.*);
  fdrc_fan_model #(.HALF_NS(197)) fdrc_fan_model_inst_2 (.tach(fan_speed_in_2));
  fdrc_fan_model #(.HALF_NS(211)) fdrc_fan_model_inst_3 (.tach(fan_speed_in_3));
  fdrc_fan_model #(.HALF_NS(223)) fdrc_fan_model_inst_4 (.tach(fan_speed_in_4));

  always #20 clk = ~clk;

  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] e);
    n_tests++;
    if (got !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, e);
    end
  endtask

  task to_chk(input int n);
    if (n >= 50)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t bus wait ran out", $time);
      tally_and_finish;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while ((aw || w) && n < 50)
    begin
      @(posedge clk);
      n++;
      if (aw && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    while (!s_axi_bvalid && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    s_axi_bready <= 1'b1;
    @(posedge clk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    to_chk(n);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    s_axi_rready <= 1'b1;
    @(posedge clk);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    to_chk(n);
  endtask

  task settle_tach(input logic [7:0] c);
    wr(8'h00, c);
    repeat (10) @(posedge clk);
    rd(8'h1C);
    t0 = rdv;
    repeat (100) @(posedge clk);
    rd(8'h1C);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h00);
    cmp(rdv, 32'h00000000);
    wr(8'h04, 8'h11);
    wr(8'h08, 8'h22);
    wr(8'h0C, 8'h33);
    wr(8'h10, 8'h77);
    cmp(rsp, 2'h0);
    wr(8'h20, 8'h55);
    cmp(rsp, 2'h2);
    rd(8'h20);
    cmp(rsp, 2'h2);
    cmp(rdv, 32'h00000000);
    s_axi_wstrb <= 4'hE;
    wr(8'h04, 8'h99);
    cmp(rsp, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'h04);
    cmp(rdv, 32'h00000011);
    $display("test registers finished");
    foreach (rows[i])
    begin
      wr(8'h00, rows[i].c);
      auto_mode <= rows[i].a;
      {below_hyst_3, below_hyst_2, below_hyst_1} <= rows[i].b;
      repeat (3) @(posedge clk);
      for (int k = 0; k < 3; k++)
      begin
        rd(8'h10 + 8'(4 * k));
        cmp(rdv, {24'h000000, rows[i].e[8 * k +: 8]});
        if (rows[i].e[8 * k +: 8] == 8'h00)
          cmp({31'h0, drive_pins[k]}, 32'h0);
        else if (rows[i].e[8 * k +: 8] == 8'hFF)
          cmp({31'h0, drive_pins[k]}, 32'h1);
      end
    end
    $display("test floor finished");
    auto_mode <= 1'b0;
    for (int c = 0; c < 8; c++)
    begin
      computed_duty_1 <= 8'h00;
      wr(8'h00, 8'(c));
      rd(8'h10);
      cmp(rdv, 32'h00000000);
      wr(8'h00, 8'(8 + c));
      computed_duty_1 <= 8'h31;
      repeat (3) @(posedge clk);
      rd(8'h10);
      cmp({31'h0, rdv[7:0] <= steps[c]}, 32'h1);
      repeat (900) @(posedge clk);
      rd(8'h10);
      cmp(rdv, 32'h00000031);
    end
    $display("test ramp finished");
    computed_duty_3 <= 8'h00;
    settle_tach(8'h00);
    cmp(rdv[23:8], t0[23:8]);
    cmp({31'h0, rdv[7:0] != t0[7:0]}, 32'h1);
    settle_tach(8'h10);
    cmp(rdv, t0);
    computed_duty_3 <= 8'hFF;
    settle_tach(8'h10);
    cmp({29'h0, rdv[23:16] != t0[23:16], rdv[15:8] != t0[15:8], rdv[7:0] != t0[7:0]}, 32'h7);
    $display("test tach finished");
    rst_n <= 1'b0;
    @(posedge clk);
    cmp({29'h0, drive_pins}, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h00);
    cmp(rdv, 32'h00000000);
    rd(8'h04);
    cmp(rdv, 32'h00000000);
    $display("test reset finished");
    tally_and_finish;
  end
endmodule

bind fdrc_top fdrc_asserts fdrc_asserts_inst (.*);
